// ---- hdl/dclp_code_ceiling.sv ----
// b-pair code ceiling register with avalon-mm slave and per-channel code clamp
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "dclp_map.svh"
//
// How it works
// - ceiling register at 4Eh, resets to 3F3Fh
// - b1 field bits 13-8, b0 bits 5-0
// - ceiling is field then seven ones
// - each field resets to 3Fh, ceiling 1FFFh
module dclp_code_ceiling (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic [11:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [15:0] ch_b0_code_i,
	input wire logic ch_b0_load_i,
	input wire logic [15:0] ch_b1_code_i,
	input wire logic ch_b1_load_i,
	output logic [15:0] ch_b0_active_o,
	output logic [15:0] ch_b1_active_o,
	output logic [12:0] ch_b0_ceiling_o,
	output logic [12:0] ch_b1_ceiling_o
);

	////////////////////////////////////////////////////////////////////////////////
	// reset release
	logic rst_meta_r; // first stage, read only by the second
	logic rst_n_r; // synchronised reset used everywhere else

	// async assert, two-flop release
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus slave
	logic ack_r; // one-cycle answer phase
	logic ack_nxt;
	logic [31:0] rdata_r; // registered read data
	logic [31:0] rdata_nxt;
	dclp_pkg::dclp_field_t b0_r; // b0 ceiling field
	dclp_pkg::dclp_field_t b0_nxt;
	dclp_pkg::dclp_field_t b1_r; // b1 ceiling field
	dclp_pkg::dclp_field_t b1_nxt;
	logic req; // read or write pending
	logic hit; // address decodes to our register
	logic [15:0] reg_view; // register as software sees it

	assign req = avs_read_i | avs_write_i;
	assign hit = (avs_address_i == `DCLP_CEIL_ADDR);
	// reserved positions are constant zero, never stored
	assign reg_view = {`DCLP_RSVD_ZERO, b1_r, `DCLP_RSVD_ZERO, b0_r};
	// wait one cycle so read data can come from a flop
	assign avs_waitrequest_o = req & ~ack_r;
	assign avs_readdata_o = rdata_r;

	// next state of the handshake, fields and read data
	always_comb begin
		ack_nxt = req & ~ack_r;
		rdata_nxt = rdata_r;
		b0_nxt = b0_r;
		b1_nxt = b1_r;
		// capture read data one edge before the answer
		if (avs_read_i & ~ack_r) begin
			// unmapped addresses read as zero
			rdata_nxt = hit ? {`DCLP_RD_ZERO, reg_view} : 32'h0000_0000;
		end
		// write lands at the edge where waitrequest is low
		if (avs_write_i & ack_r & hit) begin
			if (avs_byteenable_i[0]) begin
				b0_nxt = avs_writedata_i[`DCLP_B0_LSB +: `DCLP_FIELD_W];
			end
			if (avs_byteenable_i[1]) begin
				b1_nxt = avs_writedata_i[`DCLP_B1_LSB +: `DCLP_FIELD_W];
			end
		end
	end

	// register the slave state
	always_ff @(posedge core_clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ack_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			b0_r <= `DCLP_FIELD_RST;
			b1_r <= `DCLP_FIELD_RST;
		end else begin
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
			b0_r <= b0_nxt;
			b1_r <= b1_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// per-channel ceiling and active register clamp
	dclp_pkg::dclp_field_t fld [`DCLP_CH_NUM]; // field per channel
	logic [15:0] code_in [`DCLP_CH_NUM]; // incoming code per channel
	logic load_in [`DCLP_CH_NUM]; // latch strobe per channel
	dclp_pkg::dclp_ceil_t ceil_w [`DCLP_CH_NUM]; // decoded ceiling
	dclp_pkg::dclp_code_t act_r [`DCLP_CH_NUM]; // active register
	dclp_pkg::dclp_code_t act_nxt [`DCLP_CH_NUM];

	assign fld[0] = b0_r;
	assign fld[1] = b1_r;
	assign code_in[0] = ch_b0_code_i;
	assign code_in[1] = ch_b1_code_i;
	assign load_in[0] = ch_b0_load_i;
	assign load_in[1] = ch_b1_load_i;
	assign ch_b0_ceiling_o = ceil_w[0];
	assign ch_b1_ceiling_o = ceil_w[1];
	assign ch_b0_active_o = act_r[0];
	assign ch_b1_active_o = act_r[1];

	for (genvar g = 0; g < `DCLP_CH_NUM; g++) begin : g_ch
		// field is the top six bits, low seven bits always set
		assign ceil_w[g] = {fld[g], `DCLP_LOW_ONES};

		// clamp only at the latch; a later ceiling change does not rewrite the active code
		always_comb begin
			act_nxt[g] = act_r[g];
			if (load_in[g]) begin
				if (code_in[g] > {3'h0, ceil_w[g]}) begin
					act_nxt[g] = {3'h0, ceil_w[g]};
				end else begin
					act_nxt[g] = code_in[g];
				end
			end
		end

		// active register holds until the next load
		always_ff @(posedge core_clk_i or negedge rst_n_r) begin
			if (!rst_n_r) begin
				act_r[g] <= 16'h0000;
			end else begin
				act_r[g] <= act_nxt[g];
			end
		end

		// latched code never exceeds the ceiling in force at the latch
		property p_clamp;
			@(posedge core_clk_i) disable iff (!rst_n_r)
			load_in[g] |=> act_r[g] == (($past(code_in[g]) > {3'h0, $past(ceil_w[g])}) ?
				{3'h0, $past(ceil_w[g])} : $past(code_in[g]));
		endproperty
		a_clamp: assert property (p_clamp) else $error("active code not clamped");
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_req_start;
		req & avs_waitrequest_o;
	endsequence
	sequence s_answer;
		req & ~avs_waitrequest_o;
	endsequence

	property p_answer_next;
		@(posedge core_clk_i) disable iff (!rst_n_r)
		s_req_start |=> s_answer ##1 !ack_r;
	endproperty
	a_answer_next: assert property (p_answer_next) else $error("slave answer late");

	property p_reset_value;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		$rose(rst_n_r) |-> reg_view == `DCLP_CEIL_RST;
	endproperty
	a_reset_value: assert property (p_reset_value) else $error("bad reset value");

	property p_read_back;
		@(posedge core_clk_i) disable iff (!rst_n_r)
		(avs_read_i & ack_r & hit) |-> avs_readdata_o == {16'h0000, reg_view};
	endproperty
	a_read_back: assert property (p_read_back) else $error("read data mismatch");

	property p_rsvd_zero;
		@(posedge core_clk_i) disable iff (!rst_n_r)
		avs_read_i & ack_r |-> avs_readdata_o[15:14] == 2'h0 && avs_readdata_o[7:6] == 2'h0;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");

	property p_write_b1;
		@(posedge core_clk_i) disable iff (!rst_n_r)
		(avs_write_i & ack_r & hit & avs_byteenable_i[1]) |=>
			b1_r == $past(avs_writedata_i[`DCLP_B1_LSB +: `DCLP_FIELD_W]);
	endproperty
	a_write_b1: assert property (p_write_b1) else $error("b1 field not written");

	property p_write_b0;
		@(posedge core_clk_i) disable iff (!rst_n_r)
		(avs_write_i & ack_r & hit & avs_byteenable_i[0]) |=>
			b0_r == $past(avs_writedata_i[`DCLP_B0_LSB +: `DCLP_FIELD_W]);
	endproperty
	a_write_b0: assert property (p_write_b0) else $error("b0 field not written");

	property p_ceil_form;
		@(posedge core_clk_i) disable iff (!rst_n_r)
		ch_b1_ceiling_o[6:0] == `DCLP_LOW_ONES && ch_b1_ceiling_o[12:7] == b1_r;
	endproperty
	a_ceil_form: assert property (p_ceil_form) else $error("ceiling form wrong");

	// same shape on the b0 side, so a swapped channel wiring shows up
	property p_ceil_form_b0;
		@(posedge core_clk_i) disable iff (!rst_n_r)
		ch_b0_ceiling_o[6:0] == `DCLP_LOW_ONES && ch_b0_ceiling_o[12:7] == b0_r;
	endproperty
	a_ceil_form_b0: assert property (p_ceil_form_b0) else $error("b0 ceiling form wrong");

	property p_no_stray_write;
		@(posedge core_clk_i) disable iff (!rst_n_r)
		!(avs_write_i & ack_r & hit) |=> $stable(b0_r) && $stable(b1_r);
	endproperty
	a_no_stray_write: assert property (p_no_stray_write) else $error("field changed");

endmodule // dclp_code_ceiling

// ---- hdl/dclp_map.svh ----
// register address, reset value and field layout of the b-pair code ceiling register
`ifndef DCLP_MAP_SVH
`define DCLP_MAP_SVH
`define DCLP_CEIL_IDX 10'h04E
`define DCLP_CEIL_ADDR 12'h138
`define DCLP_CEIL_RST 16'h3F3F
`define DCLP_FIELD_RST 6'h3F
`define DCLP_B0_LSB 0
`define DCLP_B1_LSB 8
`define DCLP_FIELD_W 6
`define DCLP_LOW_ONES 7'h7F
`define DCLP_RSVD_ZERO 2'h0
`define DCLP_RD_ZERO 16'h0000
`define DCLP_CH_NUM 2
`endif

// ---- hdl/dclp_pkg.sv ----
// types shared by the b-pair code ceiling register block
package dclp_pkg;
	typedef logic [5:0] dclp_field_t;
	typedef logic [12:0] dclp_ceil_t;
	typedef logic [15:0] dclp_code_t;
endpackage

// ---- sim/dclp_code_ceiling_tb.sv ----
// self-checking bench for the b-pair code ceiling register block
`timescale 1ns/1ps
`include "dclp_map.svh"
module dclp_code_ceiling_tb;
	logic clk = 1'b0; // 250 mhz core clock
	logic rst_n = 1'b0; // active low reset
	logic [11:0] addr = 12'h000;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] be = 4'h0;
	logic [31:0] rdata;
	logic wait_req;
	logic [15:0] code0 = 16'h0000;
	logic [15:0] code1 = 16'h0000;
	logic load0 = 1'b0;
	logic load1 = 1'b0;
	logic [15:0] act0, act1;
	logic [12:0] ceil0, ceil1;
	int failures = 0; // mismatches
	int checks_done = 0; // comparisons made
	logic [31:0] q;
	////////////////////////////////////////////////////////////////
	dclp_code_ceiling uut (.core_clk_i(clk), .reset_n_i(rst_n), .avs_address_i(addr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wait_req), .ch_b0_code_i(code0),
		.ch_b0_load_i(load0), .ch_b1_code_i(code1), .ch_b1_load_i(load1),
		.ch_b0_active_o(act0), .ch_b1_active_o(act1), .ch_b0_ceiling_o(ceil0),
		.ch_b1_ceiling_o(ceil1));
	// free running clock
	initial begin
		forever #2 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////
	// one comparison, counted; a mismatch is reported at once
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	// one avalon transfer; held until waitrequest is seen low at a rising edge
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
		addr <= a;
		wdata <= d;
		be <= b;
		rd <= !w;
		wr <= w;
		// all updates are non-blocking, so right after the edge we see pre-edge values
		@(posedge clk);
		while (wait_req !== 1'b0) begin
			@(posedge clk);
		end
		// read data taken at the very edge where waitrequest was low
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		// one idle edge so the next request never reassigns in this step
		@(posedge clk);
	endtask
	// load both channels in one cycle, then look at the active codes
	task load(input logic [15:0] c0, input logic [15:0] c1, input logic [15:0] e0,
		input logic [15:0] e1);
		code0 <= c0;
		code1 <= c1;
		load0 <= 1'b1;
		load1 <= 1'b1;
		@(posedge clk);
		load0 <= 1'b0;
		load1 <= 1'b0;
		@(negedge clk);
		check({16'h0000, act0}, {16'h0000, e0});
		check({16'h0000, act1}, {16'h0000, e1});
		@(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////
	// reset values: register 3F3Fh, ceiling 1FFFh checked on the b0 channel
	task t_reset;
		bus(1'b0, `DCLP_CEIL_ADDR, 32'h00000000, 4'hF);
		check(q, 32'h00003F3F);
		check({19'h0, ceil0}, 32'h00001FFF);
		load(16'hFFFF, 16'h1234, 16'h1FFF, 16'h1234);
	endtask
	// b1 field at its smallest, b0 field at 1, reserved bits set in the write data
	task t_low_fields;
		bus(1'b1, `DCLP_CEIL_ADDR, 32'hFFFFC0C1, 4'hF);
		bus(1'b0, `DCLP_CEIL_ADDR, 32'h00000000, 4'hF);
		check(q, 32'h00000001);
		check({19'h0, ceil0}, 32'h000000FF);
		check({19'h0, ceil1}, 32'h0000007F);
		load(16'hFFFF, 16'h0080, 16'h00FF, 16'h007F);
		load(16'h0050, 16'h007F, 16'h0050, 16'h007F);
	endtask
	// distinct fields per channel, lane gating and unmapped address
	task t_fields;
		bus(1'b1, `DCLP_CEIL_ADDR, 32'h00001F05, 4'hF);
		bus(1'b1, `DCLP_CEIL_ADDR, 32'h00000000, 4'h2); // only the b1 lane
		bus(1'b1, 12'h13C, 32'h00003F3F, 4'hF); // unmapped, must be ignored
		bus(1'b0, `DCLP_CEIL_ADDR, 32'h00000000, 4'hF);
		check(q, 32'h00000005);
		bus(1'b0, 12'h13C, 32'h00000000, 4'hF);
		check(q, 32'h00000000);
		bus(1'b1, `DCLP_CEIL_ADDR, 32'h00001F3E, 4'hF);
		check({19'h0, ceil1}, 32'h00000FFF);
		load(16'h0300, 16'hFFFF, 16'h0300, 16'h0FFF);
		load(16'hFFFF, 16'h0F00, 16'h1F7F, 16'h0F00);
	endtask
	////////////////////////////////////////////////////////////////
	// verdict and end of run
	task test_done;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		t_reset;
		t_low_fields;
		t_fields;
		test_done;
	end
	// watchdog: the whole run needs well under a thousand cycles
	initial begin
		#20000;
		failures++;
		test_done;
	end
endmodule // dclp_code_ceiling_tb
